//--- src/smsp_pkg.sv
/*
  Shared constants and types for the serial master/slave port: register
  indices, field positions, reset values and the packed state records.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package smsp_pkg;

  // register word indices; byte address is index * 4
  localparam logic [1:0]  IDX_STAT     = 2'h0;
  localparam logic [1:0]  IDX_CON1     = 2'h1;
  localparam logic [1:0]  IDX_BUF      = 2'h2;
  localparam logic [1:0]  IDX_IRQ      = 2'h3;

  // status_control_reg fields
  localparam int          STAT_EN      = 15;
  localparam int          STAT_SIDL    = 13;
  localparam int          STAT_ROV     = 6;
  localparam int          STAT_TBF     = 1;
  localparam int          STAT_RBF     = 0;

  // irq register fields
  localparam int          IRQ_FLAG     = 0;
  localparam int          IRQ_EN       = 1;

  // reset values of the software-visible registers
  localparam logic [15:0] STAT_RST     = 16'h0000;
  localparam logic [15:0] CON1_RST     = 16'h0000;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  localparam logic [4:0]  BITS_BYTE    = 5'h08;
  localparam logic [4:0]  BITS_WORD    = 5'h10;

  // least divide ratio the prescaler will run at
  localparam logic [9:0]  DIV_MIN      = 10'h002;

  // control_reg_one bits 10..0, in register order
  typedef struct packed {
    logic       word;
    logic       sample_phase;
    logic       cke;
    logic       select_pin_enable;
    logic       clock_idle_polarity;
    logic       master;
    logic [2:0] spre;
    logic [1:0] ppre;
  } smsp_cfg_type;

  typedef struct packed {
    logic         aw_have;
    logic [3:0]   aw_addr;
    logic         w_have;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic         en;
    logic         sidl;
    logic         rov;
    logic         tbf;
    logic         rbf;
    smsp_cfg_type cfg;
    logic         irq_flag;
    logic         irq_en;
    logic [15:0]  txb;
    logic [15:0]  rxb;
    logic [15:0]  sr;
    logic         out;
    logic [4:0]   k_l;
    logic [4:0]   k_t;
    logic         busy;
    logic         phase;
    logic         act_prev;
  } smsp_state_type;

  typedef struct packed {
    logic [9:0] cnt;
  } smsp_div_state_type;

endpackage

//--- src/smsp_clkdiv.sv
/*
  Master shift clock prescaler: emits a lead and a trail pulse once per
  shift clock period of primary * secondary clock cycles, but at least 2.
  Assumes run is held for the whole transfer; dropping it restarts the period.
*/
`timescale 1ns/100ps
`default_nettype none

module smsp_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] ppre,
  input  wire logic [2:0] spre,
  output logic            lead,
  output logic            trail
);

  smsp_pkg::smsp_div_state_type q;
  smsp_pkg::smsp_div_state_type d;
  logic [9:0]                   ratio;
  logic [9:0]                   prim;

  // primary 1, 4, 16, 64; secondary 1..8
  always_comb begin
    prim  = 10'h001 << {ppre, 1'b0};
    // widened by one bit so that code 7 gives 8 rather than wrapping to 0
    ratio = prim * {6'h00, {1'b0, spre} + 4'h1};
    // a 1:1 overall ratio cannot make two edges per cycle
    if (ratio < smsp_pkg::DIV_MIN) begin
      ratio = smsp_pkg::DIV_MIN;
    end
  end

  assign lead  = run && (q.cnt == 10'h000);
  assign trail = run && (q.cnt == {1'b0, ratio[9:1]});

  always_comb begin
    d = q;
    if (!run || (q.cnt == ratio - 10'h001)) begin
      d.cnt = 10'h000;
    end else begin
      d.cnt = q.cnt + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

//--- src/smsp_port.sv
/*
  Serial master/slave port with double-buffered transmit and receive,
  status/control registers and an AXI4-Lite register slave.
  Assumes pins are synchronous to clk and the bus master keeps AXI rules.
*/
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - each transfer is 8 or 16 shift clocks, one bit out and in each
// - completion sets the transfer flag; interrupt passes only when enabled
// - a complete received byte or word moves into the receive buffer
// - receive buffer still full: set overflow, discard the new word
// - while overflow is set, shift clock edges are ignored
// - at transfer end move shift register to rx, then load pending tx
// - one buffer address: writes fill transmit, reads return receive
// - master starts a transfer as soon as software writes the buffer
// - shift clock pin is output in master mode, input in slave
// - a separate interrupt covers the error conditions
// - master clock is system clock over primary times secondary prescale, at least 2
// - enable bit turns the port on and claims its pins
// - halt-in-idle bit stops the port while the device idles
// - overflow flag is software clearable and set by a discarded word
// - tx full bit sets on buffer write, clears when moved to shifter
// - rx full bit sets on move into buffer, clears on buffer read
// - a 16-bit shift register plus a software-reachable buffer
// - width bit selects 16-bit words when set, bytes when clear
// - polarity bit sets idle clock level; edge bit picks output edge
// - in slave mode the select-enable bit decides use of select pin
// - master sample phase: end of output time when set, middle when clear
module smsp_port #(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire logic              cpu_idle,
  input  wire logic              sck_i,
  output logic                   sck_o,
  output logic                   sck_oe,
  input  wire logic              sdi,
  output logic                   sdo_o,
  output logic                   sdo_oe,
  input  wire logic              ss_n_i,
  output logic                   transfer_irq,
  output logic                   error_irq
);

  smsp_pkg::smsp_state_type q;
  smsp_pkg::smsp_state_type d;

  logic        halt;
  logic        ss_off;
  logic        go;
  logic        act;
  logic        m_lead;
  logic        m_trail;
  logic        run;
  logic        lead;
  logic        trail;
  logic        smp_eff;
  logic        smpl;
  logic        chg;
  logic        last_t;
  logic        done;
  logic        idle_x;
  logic        load;
  logic        bit_cur;
  logic        bit_nxt;
  logic [4:0]  nbits;
  logic [15:0] sr_n;
  logic [15:0] rx_word;
  logic [15:0] stat_rd;
  logic [15:0] con1_rd;
  logic [15:0] irq_rd;
  logic [15:0] rd_val;
  logic [15:0] nw;
  logic [2:0]  wsel;
  logic [2:0]  rsel;
  logic        wr_do;
  logic        rd_take;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // {hit, index}: aligned word inside the four-register window
  function automatic logic [2:0] dec(input logic [ADDR_W-1:0] a);
    dec = {(a[1:0] == 2'h0) && ((a >> 4) == '0), a[3:2]};
  endfunction

  // byte-lane merge for the low 16 bits of a register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nv,
                                        input logic [1:0]  strb);
    merge = {strb[1] ? nv[15:8] : old[15:8], strb[0] ? nv[7:0] : old[7:0]};
  endfunction

  smsp_clkdiv u_div (
    .clk   (clk),
    .rst   (rst),
    .run   (run),
    .ppre  (q.cfg.ppre),
    .spre  (q.cfg.spre),
    .lead  (m_lead),
    .trail (m_trail)
  );

  // edge detection and gating of the transfer engine
  assign halt    = q.sidl & cpu_idle;
  assign ss_off  = ~q.cfg.master & q.cfg.select_pin_enable & ss_n_i;
  assign go      = q.en & ~halt & ~q.rov & ~ss_off;
  assign run     = go & q.cfg.master & q.busy;
  assign act     = sck_i ^ q.cfg.clock_idle_polarity;
  assign lead    = go & (q.cfg.master ? (q.busy & m_lead) : (act & ~q.act_prev));
  assign trail   = go & (q.cfg.master ? (q.busy & m_trail) : (~act & q.act_prev));
  assign nbits   = q.cfg.word ? smsp_pkg::BITS_WORD : smsp_pkg::BITS_BYTE;
  assign last_t  = (q.k_t == nbits - 5'h01);
  // sample phase has no meaning for a slave, so it is forced clear there
  assign smp_eff = q.cfg.sample_phase & q.cfg.master;
  assign chg     = q.cfg.cke ? trail : lead;
  assign smpl    = q.cfg.cke ? (smp_eff ? trail : lead)
                 : (smp_eff ? ((lead & (q.k_l != 5'h00)) | (trail & last_t)) : trail);
  assign done    = trail & last_t;
  assign sr_n    = smpl ? {q.sr[14:0], sdi} : q.sr;
  assign bit_cur = q.cfg.word ? q.sr[15] : q.sr[7];
  assign bit_nxt = q.cfg.word ? q.sr[14] : q.sr[6];
  assign rx_word = q.cfg.word ? sr_n : {8'h00, sr_n[7:0]};
  assign idle_x  = (q.k_l == 5'h00) & (q.k_t == 5'h00) & ~q.busy;
  assign load    = q.en & ~halt & ~q.rov & q.tbf & idle_x;

  // register views
  assign stat_rd = {q.en, 1'b0, q.sidl, 6'h00, q.rov, 4'h0, q.tbf, q.rbf};
  assign con1_rd = {5'h00, q.cfg};
  assign irq_rd  = {14'h0000, q.irq_en, q.irq_flag};

  assign wsel    = dec(q.aw_addr[ADDR_W-1:0]);
  assign rsel    = dec(s_axi_araddr);
  assign wr_do   = q.aw_have & q.w_have & ~q.bvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;

  always_comb begin
    case (rsel[1:0])
      smsp_pkg::IDX_STAT: rd_val = stat_rd;
      smsp_pkg::IDX_CON1: rd_val = con1_rd;
      smsp_pkg::IDX_BUF:  rd_val = q.rxb;
      smsp_pkg::IDX_IRQ:  rd_val = irq_rd;
      default:            rd_val = 16'h0000;
    endcase
  end

  always_comb begin
    d          = q;
    nw         = 16'h0000;
    d.act_prev = act;

    // bus channels
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = 4'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_take) begin
      d.rvalid = 1'b1;
      d.rresp  = rsel[2] ? smsp_pkg::RESP_OKAY : smsp_pkg::RESP_SLVERR;
      d.rdata  = rsel[2] ? {16'h0000, rd_val} : 32'h0000_0000;
      if (rsel == {1'b1, smsp_pkg::IDX_BUF}) begin
        d.rbf = 1'b0;
      end
    end

    // shift engine
    if (lead) begin
      d.k_l   = q.k_l + 5'h01;
      d.phase = 1'b1;
    end
    if (trail) begin
      d.k_t   = q.k_t + 5'h01;
      d.phase = 1'b0;
    end
    d.sr = sr_n;
    if (chg) begin
      // when sampling on the same edge the old msb has already left
      d.out = smpl ? bit_nxt : bit_cur;
    end
    if (done) begin
      d.k_l      = 5'h00;
      d.k_t      = 5'h00;
      d.busy     = 1'b0;
      if (!q.rbf) begin
        d.rxb = rx_word;
      end
    end
    if (!q.en || ss_off) begin
      d.k_l   = 5'h00;
      d.k_t   = 5'h00;
      d.busy  = 1'b0;
      d.phase = 1'b0;
    end
    if (load) begin
      d.sr   = q.txb;
      d.out  = q.cfg.word ? q.txb[15] : q.txb[7];
      d.tbf  = 1'b0;
      d.busy = q.cfg.master;
    end

    // software writes
    if (wr_do) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wsel[2] ? smsp_pkg::RESP_OKAY : smsp_pkg::RESP_SLVERR;
      if (wsel[2]) begin
        case (wsel[1:0])
          smsp_pkg::IDX_STAT: begin
            nw     = merge(stat_rd, q.w_data[15:0], q.w_strb[1:0]);
            d.en   = nw[smsp_pkg::STAT_EN];
            d.sidl = nw[smsp_pkg::STAT_SIDL];
            if (!nw[smsp_pkg::STAT_ROV]) begin
              d.rov = 1'b0;
            end
          end
          smsp_pkg::IDX_CON1: begin
            nw    = merge(con1_rd, q.w_data[15:0], q.w_strb[1:0]);
            d.cfg = nw[10:0];
          end
          smsp_pkg::IDX_BUF: begin
            // a full transmit buffer is overwritten; the older word is lost
            d.txb = merge(q.txb, q.w_data[15:0], q.w_strb[1:0]);
            d.tbf = 1'b1;
          end
          smsp_pkg::IDX_IRQ: begin
            if (q.w_strb[0]) begin
              if (q.w_data[smsp_pkg::IRQ_FLAG]) begin
                d.irq_flag = 1'b0;
              end
              d.irq_en = q.w_data[smsp_pkg::IRQ_EN];
            end
          end
          default: begin
            nw = 16'h0000;
          end
        endcase
      end
    end

    // hardware sets win over a clear in the same cycle
    if (done) begin
      d.irq_flag = 1'b1;
      if (q.rbf) begin
        d.rov = 1'b1;
      end else begin
        d.rbf = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = ~q.aw_have & ~q.bvalid;
  assign s_axi_wready  = ~q.w_have & ~q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  assign sck_o         = q.cfg.clock_idle_polarity ^ q.phase;
  assign sck_oe        = q.en & q.cfg.master;
  assign sdo_o         = q.out;
  assign sdo_oe        = q.en & ~ss_off;
  assign transfer_irq  = q.irq_flag & q.irq_en;
  assign error_irq     = q.rov;

  sequence s_buf_wr;
    wr_do && (wsel == {1'b1, smsp_pkg::IDX_BUF});
  endsequence

  sequence s_ready_master;
    q.cfg.master && q.en && !q.rov && !halt && idle_x;
  endsequence

  a_tbf_on_write: assert property (s_buf_wr |=> q.tbf)
    else $error("tx full not set after buffer write");
  a_master_start: assert property (s_buf_wr ##1 s_ready_master |=> q.busy && !q.tbf)
    else $error("master did not start after buffer write");
  a_rx_move: assert property (done && !q.rbf |=> q.rbf && (q.rxb == $past(rx_word)))
    else $error("received word not moved to buffer");
  a_ovf_discard: assert property (done && q.rbf |=> q.rov && $stable(q.rxb))
    else $error("overflow not flagged or buffer overwritten");
  a_rov_freeze: assert property (q.rov |-> !lead && !trail)
    else $error("clock edge acted on while overflow set");
  a_rd_clear: assert property (rd_take && (rsel == {1'b1, smsp_pkg::IDX_BUF}) && !done
                               |=> !q.rbf)
    else $error("rx full not cleared by buffer read");
  a_bit_count: assert property (done |-> q.k_l == nbits)
    else $error("transfer ended with wrong number of clocks");
  a_irq_flag: assert property (done |=> q.irq_flag ##0 (transfer_irq == q.irq_en))
    else $error("transfer flag or gated interrupt wrong");
  a_sck_dir: assert property (sck_oe == (q.en && q.cfg.master))
    else $error("shift clock direction wrong");
  a_slave_quiet: assert property (ss_off |-> !sdo_oe && !lead && !trail)
    else $error("deselected slave drove data or took clocks");
  a_idle_halt: assert property (halt |-> !lead && !trail ##1 (halt || !run || m_lead))
    else $error("port ran while halted in idle");

endmodule

`default_nettype wire

//--- tb/smsp_peer.sv
/*
  Far-side serial peer: a slave when the port is master, and a frame
  driving master when the port is a slave.
  Assumes the bench sets ckp and cke to the port's settings before each load.
*/
`timescale 1ns/100ps
`default_nettype none

module smsp_peer (
  input  wire logic clk,
  input  wire logic clock_idle_polarity,
  input  wire logic cke,
  input  wire logic sck_o,
  input  wire logic sck_oe,
  input  wire logic sdo_o,
  input  wire logic sdo_oe,
  output logic      sck_i,
  output logic      sdi,
  output logic      ss_n_i
);
  logic [15:0] tx_q = 16'h0000;
  logic [15:0] rx_q = 16'h0000;
  logic        last_q = 1'b0;
  logic        sdo_w;
  time         lead_at = 0;
  int          period = 0;

  // a released line shows the inverse, so a stale bit never passes
  assign sdo_w = sdo_oe ? sdo_o : ~last_q;

  initial begin
    sck_i = 1'b0;
    sdi = 1'b0;
    ss_n_i = 1'b1;
  end

  always @(posedge clk) begin
    if (sdo_oe) last_q <= sdo_o;
  end

  // capture on the edge opposite the port's output change; the next bit is
  // presented on the trailing edge; only a driven clock counts, so a slave
  // port's internal phase never disturbs a frame
  always @(sck_o) begin
    if (sck_oe === 1'b1) begin
      if ((sck_o ^ clock_idle_polarity) === 1'b1) begin
        if (cke) rx_q = {rx_q[14:0], sdo_w};
        period = int'(($time - lead_at) / 10);
        lead_at = $time;
      end else begin
        if (!cke) rx_q = {rx_q[14:0], sdo_w};
        tx_q = {tx_q[14:0], 1'b0};
        sdi <= tx_q[15];
      end
    end
  end

  task automatic load(input logic [15:0] val);
    tx_q = val;
    rx_q = 16'h0000;
    sdi <= val[15];
  endtask

  // first bit sits in bit 15; four clk cycles per clock phase
  task automatic frame(input logic [15:0] val, input int n, input logic sel_n);
    tx_q = val;
    rx_q = 16'h0000;
    @(posedge clk);
    ss_n_i <= sel_n;
    sck_i <= clock_idle_polarity;
    sdi <= val[15];
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sck_i <= ~clock_idle_polarity;
      rx_q = {rx_q[14:0], sdo_w};
      repeat (4) @(posedge clk);
      sck_i <= clock_idle_polarity;
      tx_q = {tx_q[14:0], 1'b0};
      sdi <= tx_q[15];
      repeat (4) @(posedge clk);
    end
    ss_n_i <= 1'b1;
    sdi <= ~sdi;
  endtask
endmodule

`default_nettype wire

//--- tb/smsp_tb.sv
/*
  Self-checking bench for the serial port: bus tasks, one task a scenario.
  Assumes smsp_pkg, smsp_port and smsp_peer are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam logic [3:0] A_STAT = {smsp_pkg::IDX_STAT, 2'b00};
  localparam logic [3:0] A_CON1 = {smsp_pkg::IDX_CON1, 2'b00};
  localparam logic [3:0] A_BUF = {smsp_pkg::IDX_BUF, 2'b00};
  localparam logic [3:0] A_IRQ = {smsp_pkg::IDX_IRQ, 2'b00};
  localparam logic [15:0] EN = 16'h0001 << smsp_pkg::STAT_EN;
  localparam logic [15:0] SIDL = 16'h0001 << smsp_pkg::STAT_SIDL;
  localparam logic [15:0] ROV = 16'h0001 << smsp_pkg::STAT_ROV;
  localparam logic [15:0] TBF = 16'h0001 << smsp_pkg::STAT_TBF;
  localparam logic [15:0] RBF = 16'h0001 << smsp_pkg::STAT_RBF;

  logic        clk = 1'b0, rst = 1'b1, cpu_idle = 1'b0, clock_idle_polarity = 1'b0, cke = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic        sck_i, sck_o, sck_oe, sdi, sdo_o, sdo_oe, ss_n_i, t_irq, e_irq;
  logic [15:0] v;
  int          mismatches = 0, num_checks = 0, cycles = 0;

  smsp_port dut (
    .clk(clk), .rst(rst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .cpu_idle(cpu_idle), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ss_n_i(ss_n_i), .transfer_irq(t_irq), .error_irq(e_irq));

  smsp_peer peer (.clk(clk), .clock_idle_polarity(clock_idle_polarity), .cke(cke), .sck_o(sck_o), .sck_oe(sck_oe),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sck_i(sck_i), .sdi(sdi), .ss_n_i(ss_n_i));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("wrong value cycles expected below 20000 seen 20000");
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ready is looked at 1 ns after an edge, so it holds through the next edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic ah, wh, bh;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= 4'hF;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      #1;
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid === 1'b1;
      r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    logic ah, dh;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    dh = 1'b0;
    while (!dh) begin
      #1;
      ah = arvalid & arready;
      dh = rvalid === 1'b1;
      v = rdata[15:0];
      r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [3:0] a, input logic [15:0] e);
    rd(a);
    chk(nm, e, v);
  endtask

  task automatic wait_irq(input logic err);
    int n;
    n = 0;
    while ((err ? e_irq : t_irq) !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("irq wait", 16'h0001, 16'(err ? e_irq : t_irq));
  endtask

  task automatic setup(input logic [15:0] con);
    wr(A_STAT, 16'h0000);
    wr(A_CON1, con); // mode bits while the port is still disabled
    wr(A_STAT, 16'h0000); // overflow cleared before enabling
    wr(A_STAT, EN);
    clock_idle_polarity <= con[6];
    cke <= con[8];
    #1;
    chk("idle clock", 16'(con[6]), 16'(sck_o));
    chk("sck drive", 16'(con[5]), 16'(sck_oe));
  endtask

  task automatic master_xfer(input logic [15:0] con, input logic [15:0] tx,
                             input logic [15:0] pv, input int ratio);
    logic [15:0] m;
    m = con[10] ? 16'hFFFF : 16'h00FF;
    setup(16'h0020 | con);
    peer.load(con[10] ? pv : pv << 8);
    wr(A_BUF, tx);
    wait_irq(1'b0);
    chk("peer rx", tx & m, peer.rx_q & m);
    chk("sck period", 16'(ratio), 16'(peer.period));
    rdc("stat done", A_STAT, EN | RBF);
    rdc("rx data", A_BUF, pv & m);
    rdc("stat read", A_STAT, EN);
    rdc("irq flag", A_IRQ, 16'h0003);
    wr(A_IRQ, 16'h0003);
    #1;
    chk("irq cleared", 16'h0000, 16'(t_irq));
  endtask

  task automatic t_regs();
    rdc("stat reset", A_STAT, smsp_pkg::STAT_RST);
    rdc("con1 reset", A_CON1, smsp_pkg::CON1_RST);
    rd(4'h2);
    chk("rresp odd", 16'(smsp_pkg::RESP_SLVERR), 16'(r));
    wr(4'h6, 16'hFFFF);
    chk("bresp odd", 16'(smsp_pkg::RESP_SLVERR), 16'(r));
    #1;
    chk("pins off", 16'h0000, 16'({sck_oe, sdo_oe}));
  endtask

  // second word waits in the transmit buffer; the receive side overflows
  task automatic t_pending();
    peer.load(16'hA55A);
    wr(A_BUF, 16'h0011);
    wr(A_BUF, 16'h0022);
    rdc("tx pending", A_STAT, EN | TBF);
    wait_irq(1'b1);
    rdc("overflow", A_STAT, EN | ROV | RBF);
    chk("error irq", 16'h0001, 16'(e_irq));
    chk("second out", 16'h0022, peer.rx_q & 16'h00FF);
    rdc("first kept", A_BUF, 16'h00A5);
    wr(A_STAT, EN | ROV);
    rdc("ov sticky", A_STAT, EN | ROV);
    wr(A_STAT, EN);
    rdc("ov cleared", A_STAT, EN);
    wr(A_IRQ, 16'h0003);
  endtask

  task automatic t_halt();
    wr(A_STAT, EN | SIDL);
    cpu_idle <= 1'b1;
    peer.load(16'h6900);
    wr(A_BUF, 16'h0033);
    repeat (200) @(posedge clk);
    rdc("halted", A_IRQ, 16'h0002);
    cpu_idle <= 1'b0;
    wait_irq(1'b0);
    rdc("resumed", A_BUF, 16'h0069);
    wr(A_IRQ, 16'h0003);
  endtask

  task automatic t_slave();
    rd(A_BUF); // a buffer read first clears any leftover rx full flag
    setup(16'h0180);
    chk("sdo released", 16'h0000, 16'(sdo_oe));
    wr(A_BUF, 16'h0096);
    peer.frame(16'hFFFF, 8, 1'b1);
    rdc("deselected", A_IRQ, 16'h0002);
    peer.frame(16'h5A00, 8, 1'b0);
    chk("slave tx", 16'h0096, peer.rx_q & 16'h00FF);
    rdc("slave rx", A_BUF, 16'h005A);
    peer.frame(16'h1200, 8, 1'b0);
    peer.frame(16'h3400, 8, 1'b0);
    rdc("slave kept", A_BUF, 16'h0012);
    peer.frame(16'h5600, 8, 1'b0);
    rdc("frozen", A_STAT, EN | ROV);
    wr(A_STAT, 16'h0000);
    #1;
    chk("off", 16'h0000, 16'({sck_oe, sdo_oe}));
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    wr(A_IRQ, 16'h0002);
    master_xfer(16'h0102, 16'h003C, 16'h00A5, 16);
    master_xfer(16'h0709, 16'hC3E1, 16'h5A96, 12);
    master_xfer(16'h005D, 16'h0081, 16'h007E, 32);
    t_pending();
    t_halt();
    t_slave();
    finish_test();
  end
endmodule

`default_nettype wire
